// >>> rtl/adcc_ctrl.sv
// Converter control core: configuration, offset and gain registers,
// reset cycle, calibration sequencing and port-flag data output.
// Assumes a command decoder on sys_clk drives the register strobes and
// that crystal, serial clock and select pins are asynchronous.
//
// Notes on behaviour
// (R01) Eight decimation rates, figures at crystal 32.768 kHz
// (R02) Every conversion fully settled; mains rejection
// (R03) Filter timing derived only from crystal clock
// (R04) External crystal clock kept at 100 kHz max
// (R05) Writing reset bit one starts reset cycle
// (R06) Cycle end resets port, sets reset-valid
// (R07) Reset values: config, offset zero, unity gain
// (R08) Reset-valid clears on configuration register read
// (R09) Host writes reset bit zero to resume
// (R10) Port flag zero: data via read command
// (R11) Port flag one: nop, then 24 clocks out
// (R12) Single calibration step: one cycle, then done
// (R13) Code 011: offset then gain, done after
// (R14) Done clears on data/offset/gain/setup reads
// (R15) Uncalibrated conversions use reset offset and gain
// (R16) Offset calibration result trims later conversions
// (R17) Offset register 24 bits, LSB 2^-24 span
// (R18) Offset bit 23 is sign, one negative
// (R19) Offset aligns with data from MSB
// (R20) Gain unsigned fixed point, bit 22 weighs one
// (R21) Gain reset unity; calibration overwrites slope
// (R22) Calibration field picks self or system
// (R23) Port flag one: data out low at done
// (R24) Reset bit sits at configuration bit 7
// (R25) Select codes: offset, gain, config, data
// (R26) Rate field sets conversion length in crystal cycles
// (R27) Reset bit held: conversion, calibration idle
`timescale 1ns/1ns
module adcc_ctrl (
	// Clock, reset, enable
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        ce,
	// Crystal pins
	input  wire logic        crystal_clock_input,
	output logic             crystal_drive_output,
	// Serial pins
	input  wire logic        cs_n,
	input  wire logic        sclk,
	output logic             sdo,
	output logic             sdo_oe,
	// Command decoder port
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [2:0]  register_select_field,
	input  wire logic [23:0] reg_wdata,
	input  wire logic        nop_cmd,
	output logic [23:0]      reg_rdata,
	output logic             reg_rvalid,
	output logic             port_reset,
	// Modulator word
	input  wire logic [23:0] mod_word,
	// Status and analog control
	output logic             conv_valid,
	output logic             reset_active,
	output logic [2:0]       cal_route,
	output logic [1:0]       latch_a,
	output logic [3:0]       latch_d,
	output logic             low_power,
	output logic             unipolar,
	output logic             power_save_sel
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic                xs1;
		logic                xs2;
		logic                xs3;
		logic                ss1;
		logic                ss2;
		logic                ss3;
		logic                cs1;
		logic                cs2;

		logic                xdrv;
		logic                tick;

		logic [23:0]         cfg;
		logic [23:0]         offset_trim;
		logic [23:0]         gain_slope;
		logic [23:0]         data;
		logic [23:0]         rdata;
		logic                rvalid;

		logic                conv_p;
		logic                rst_busy;
		logic [9:0]          rst_cnt;
		logic                port_rst;
		logic                tmr_restart;

		adcc_pkg::adcc_cal_t cal;

		logic                sdo_ready;
		logic [23:0]         shreg;
		logic [4:0]          bitcnt;

		logic                sdo;
		logic                sdo_oe;
		logic [2:0]          route;
	} adcc_state_t;

	adcc_state_t s_r;
	adcc_state_t s_nxt;
	adcc_core_if core_if ();

	logic rs_hold;
	logic sclk_fall;
	logic cs_low;
	logic pf;

	// ------------------------------------------------------------
	// Submodules
	// ------------------------------------------------------------
	adcc_rate_timer u_timer (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.ce      (ce),
		.core    (core_if.timer)
	);

	adcc_corrector u_corr (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.ce      (ce),
		.core    (core_if.corr)
	);

	assign core_if.xtal_tick = s_r.tick; // R03 R01
	assign core_if.run       = ~(rs_hold | s_r.tmr_restart); // R27
	assign core_if.rate_sel  = s_r.cfg[adcc_pkg::CFG_RATE_HI:adcc_pkg::CFG_RATE_LO]; // R26
	assign core_if.raw       = mod_word;
	assign core_if.trim      = s_r.offset_trim; // R15 R16
	assign core_if.slope     = s_r.gain_slope; // R15

	assign rs_hold   = s_r.cfg[adcc_pkg::CFG_RS] | s_r.rst_busy;
	assign sclk_fall = ~s_r.ss2 & s_r.ss3;
	assign cs_low    = ~s_r.cs2;
	assign pf        = s_r.cfg[adcc_pkg::CFG_PF];

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;

		// Pin synchronisers and crystal edge
		s_nxt.xs1  = crystal_clock_input;
		s_nxt.xs2  = s_r.xs1;
		s_nxt.xs3  = s_r.xs2;
		s_nxt.ss1  = sclk;
		s_nxt.ss2  = s_r.ss1;
		s_nxt.ss3  = s_r.ss2;
		s_nxt.cs1  = cs_n;
		s_nxt.cs2  = s_r.cs1;
		s_nxt.xdrv = ~s_r.xs2;
		s_nxt.tick = s_r.xs2 & ~s_r.xs3;

		s_nxt.port_rst    = 1'b0;
		s_nxt.rvalid      = 1'b0;
		s_nxt.conv_p      = 1'b0;
		s_nxt.tmr_restart = 1'b0;

		// Reset cycle
		if (s_r.rst_busy && s_r.tick) begin
			if (s_r.rst_cnt == adcc_pkg::RESET_XTAL_CYCLES - 10'h001) begin
				s_nxt.rst_busy    = 1'b0;
				s_nxt.rst_cnt     = 10'h000;
				s_nxt.cfg         = adcc_pkg::CFG_RESET; // R07 R06
				s_nxt.cfg[adcc_pkg::CFG_RS] = s_r.cfg[adcc_pkg::CFG_RS]; // R09
				s_nxt.offset_trim = adcc_pkg::OFFSET_RESET; // R07
				s_nxt.gain_slope  = adcc_pkg::GAIN_RESET; // R21
				s_nxt.port_rst    = 1'b1; // R06
				s_nxt.cal         = adcc_pkg::CAL_IDLE;
				s_nxt.sdo_ready   = 1'b0;
				s_nxt.bitcnt      = 5'h00;
			end else begin
				s_nxt.rst_cnt = s_r.rst_cnt + 10'h001;
			end
		end

		// Register writes
		if (reg_wr) begin
			unique case (register_select_field) // R25
				adcc_pkg::SEL_OFFSET: s_nxt.offset_trim = reg_wdata; // R17
				adcc_pkg::SEL_GAIN:   s_nxt.gain_slope  = reg_wdata; // R21
				adcc_pkg::SEL_CONFIG: begin
					s_nxt.cfg = (reg_wdata & adcc_pkg::CFG_WMASK)
					          | (s_nxt.cfg & ~adcc_pkg::CFG_WMASK);
					s_nxt.tmr_restart = 1'b1;
					s_nxt.cal = adcc_pkg::CAL_IDLE;
					if (reg_wdata[adcc_pkg::CFG_RS]) begin
						s_nxt.rst_busy = 1'b1; // R05 R24
						s_nxt.rst_cnt  = 10'h000;
					end else begin
						unique case (reg_wdata[1:0]) // R22
							adcc_pkg::CC_OFFSET: s_nxt.cal = adcc_pkg::CAL_OFFSET;
							adcc_pkg::CC_BOTH:   s_nxt.cal = adcc_pkg::CAL_OFFSET; // R13
							adcc_pkg::CC_GAIN:   s_nxt.cal = adcc_pkg::CAL_GAIN;
							default:             s_nxt.cal = adcc_pkg::CAL_IDLE;
						endcase
					end
				end
				default: ;
			endcase
		end

		// Register reads and their side effects
		if (reg_rd) begin
			s_nxt.rvalid = 1'b1;
			unique case (register_select_field) // R25
				adcc_pkg::SEL_OFFSET: s_nxt.rdata = s_r.offset_trim;
				adcc_pkg::SEL_GAIN:   s_nxt.rdata = s_r.gain_slope;
				adcc_pkg::SEL_CONFIG: s_nxt.rdata = s_r.cfg;
				adcc_pkg::SEL_DATA:   s_nxt.rdata = s_r.data; // R10
				adcc_pkg::SEL_SETUP:  s_nxt.rdata = s_r.offset_trim;
				default:              s_nxt.rdata = 24'h000000;
			endcase
			if (register_select_field == adcc_pkg::SEL_CONFIG)
				s_nxt.cfg[adcc_pkg::CFG_RV] = s_nxt.port_rst; // R08 R06
			else if (register_select_field <= adcc_pkg::SEL_SETUP)
				s_nxt.cfg[adcc_pkg::CFG_DF] = 1'b0; // R14
		end

		// No-operation command opens a word shift when the port flag is set
		if (nop_cmd) begin
			s_nxt.sdo_ready = 1'b0; // R11
			if (pf) begin
				s_nxt.shreg  = s_r.data;
				s_nxt.bitcnt = adcc_pkg::SHIFT_BITS; // R11
			end
		end

		// Conversion end: data word or calibration step
		if (core_if.conv_end && !rs_hold) begin
			unique case (s_r.cal)
				adcc_pkg::CAL_IDLE: begin
					s_nxt.data   = core_if.result; // R02 R15
					s_nxt.conv_p = 1'b1;
					if (pf)
						s_nxt.sdo_ready = 1'b1;
				end
				adcc_pkg::CAL_OFFSET: begin
					s_nxt.offset_trim = adcc_pkg::sm_from_tc(mod_word); // R16
					if (s_r.cfg[1:0] == adcc_pkg::CC_BOTH) begin
						s_nxt.cal = adcc_pkg::CAL_GAIN; // R13
					end else begin
						s_nxt.cal = adcc_pkg::CAL_IDLE;
						s_nxt.cfg[adcc_pkg::CFG_CC_HI:adcc_pkg::CFG_CC_LO] = 3'h0; // R12
						s_nxt.cfg[adcc_pkg::CFG_DF] = 1'b1; // R12
						s_nxt.sdo_ready = pf | s_nxt.sdo_ready; // R23
					end
				end
				adcc_pkg::CAL_GAIN: begin
					s_nxt.gain_slope = mod_word; // R21
					s_nxt.cal = adcc_pkg::CAL_IDLE;
					s_nxt.cfg[adcc_pkg::CFG_CC_HI:adcc_pkg::CFG_CC_LO] = 3'h0; // R12 R13
					s_nxt.cfg[adcc_pkg::CFG_DF] = 1'b1; // R13
					s_nxt.sdo_ready = pf | s_nxt.sdo_ready; // R23
				end
				default: s_nxt.cal = adcc_pkg::CAL_IDLE;
			endcase
		end

		// Hold while the reset bit stands
		if (s_nxt.cfg[adcc_pkg::CFG_RS] || s_nxt.rst_busy) begin
			s_nxt.offset_trim = adcc_pkg::OFFSET_RESET; // R27
			s_nxt.gain_slope  = adcc_pkg::GAIN_RESET; // R27
			s_nxt.cal         = adcc_pkg::CAL_IDLE; // R27
			s_nxt.conv_p      = 1'b0; // R27
			s_nxt.data        = s_r.data; // R27
		end

		// Serial word shift, data changes on falling clock
		if (s_r.bitcnt != 5'h00 && cs_low && sclk_fall) begin
			s_nxt.shreg  = {s_r.shreg[22:0], 1'b0}; // R11
			s_nxt.bitcnt = s_r.bitcnt - 5'h01;
		end

		// Reset-cycle end drops any word in flight
		if (s_nxt.port_rst) begin
			s_nxt.bitcnt    = 5'h00; // R06
			s_nxt.sdo_ready = 1'b0;
		end

		// Pin and status outputs
		if (s_nxt.bitcnt != 5'h00)
			s_nxt.sdo = s_nxt.shreg[23];
		else
			s_nxt.sdo = ~(s_nxt.cfg[adcc_pkg::CFG_PF] & s_nxt.sdo_ready); // R23
		s_nxt.sdo_oe = ~s_r.cs2;
		s_nxt.route  = {s_nxt.cfg[adcc_pkg::CFG_CC_SYSTEM], // R22
		                s_nxt.cal == adcc_pkg::CAL_GAIN,
		                s_nxt.cal != adcc_pkg::CAL_IDLE};
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			s_r             <= '0;
			s_r.cfg         <= adcc_pkg::CFG_RESET; // R07
			s_r.gain_slope  <= adcc_pkg::GAIN_RESET; // R21
			s_r.offset_trim <= adcc_pkg::OFFSET_RESET;
			s_r.cal         <= adcc_pkg::CAL_IDLE;
			s_r.sdo         <= 1'b1;
			// Select idles high so sdo_oe stays low after reset
			s_r.cs1         <= 1'b1;
			s_r.cs2         <= 1'b1;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign crystal_drive_output = s_r.xdrv;
	assign sdo                  = s_r.sdo;
	assign sdo_oe               = s_r.sdo_oe;
	assign reg_rdata            = s_r.rdata;
	assign reg_rvalid           = s_r.rvalid;
	assign port_reset           = s_r.port_rst;
	assign conv_valid           = s_r.conv_p;
	assign reset_active         = s_r.rst_busy;
	assign cal_route            = s_r.route;

	assign latch_a              = s_r.cfg[adcc_pkg::CFG_LATCH_A_HI:adcc_pkg::CFG_LATCH_A_LO];
	assign latch_d              = s_r.cfg[adcc_pkg::CFG_LATCH_D_HI:adcc_pkg::CFG_LATCH_D_LO];
	assign low_power            = s_r.cfg[adcc_pkg::CFG_LPM];
	assign unipolar             = s_r.cfg[adcc_pkg::CFG_UNIPOLAR];
	assign power_save_sel       = s_r.cfg[adcc_pkg::CFG_PSS];
endmodule

// >>> rtl/adcc_pkg.sv
// Shared constants, types and helpers for the converter control block.
// Assumes a single 20 MHz system clock; crystal counts are in crystal cycles.
package adcc_pkg;

	// ------------------------------------------------------------
	// Register selects and widths
	// ------------------------------------------------------------
	localparam int       WORD_W     = 24;
	localparam logic [2:0] SEL_OFFSET = 3'h0;
	localparam logic [2:0] SEL_GAIN   = 3'h1;
	localparam logic [2:0] SEL_CONFIG = 3'h2;
	localparam logic [2:0] SEL_DATA   = 3'h3;
	localparam logic [2:0] SEL_SETUP  = 3'h4;

	// ------------------------------------------------------------
	// Configuration field positions
	// ------------------------------------------------------------
	localparam int CFG_LATCH_A_HI = 23;
	localparam int CFG_LATCH_A_LO = 22;
	localparam int CFG_LATCH_D_HI = 21;
	localparam int CFG_LATCH_D_LO = 18;
	localparam int CFG_LPM        = 16;
	localparam int CFG_RATE_HI    = 15;
	localparam int CFG_RATE_LO    = 13;
	localparam int CFG_UNIPOLAR   = 12;
	localparam int CFG_RS         = 7;
	localparam int CFG_RV         = 6;
	localparam int CFG_PF         = 5;
	localparam int CFG_PSS        = 4;
	localparam int CFG_DF         = 3;
	localparam int CFG_CC_SYSTEM  = 2;
	localparam int CFG_CC_HI      = 2;
	localparam int CFG_CC_LO      = 0;

	// ------------------------------------------------------------
	// Reset values, masks and counts
	// ------------------------------------------------------------
	localparam logic [23:0] CFG_RESET     = 24'h000040;
	localparam logic [23:0] OFFSET_RESET  = 24'h000000;
	localparam logic [23:0] GAIN_RESET    = 24'h400000;
	localparam logic [23:0] CFG_WMASK     = 24'hFDF0B7;
	localparam logic [9:0]  RESET_XTAL_CYCLES = 10'h3EA;
	localparam logic [4:0]  SHIFT_BITS    = 5'h18;
	localparam logic [1:0]  CC_OFFSET     = 2'h1;
	localparam logic [1:0]  CC_GAIN       = 2'h2;
	localparam logic [1:0]  CC_BOTH       = 2'h3;

	typedef enum logic [1:0] {CAL_IDLE, CAL_OFFSET, CAL_GAIN} adcc_cal_t;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Conversion cycle length in crystal cycles per rate code
	function automatic logic [14:0] rate_cycles(input logic [2:0] r);
		unique case (r)
			3'h0: return 15'h0884;
			3'h1: return 15'h0444;
			3'h2: return 15'h0214;
			3'h3: return 15'h0184;
			3'h4: return 15'h0144;
			3'h5: return 15'h4424;
			3'h6: return 15'h2214;
			3'h7: return 15'h110C;
		endcase
	endfunction

	// Two's complement word to sign and magnitude trim
	function automatic logic [23:0] sm_from_tc(input logic [23:0] v);
		logic [23:0] m;
		m = v[23] ? (24'h000000 - v) : v;
		if (m[23])
			m = 24'h7FFFFF;
		return {v[23], m[22:0]};
	endfunction

endpackage

// >>> rtl/adcc_core_if.sv
// Link between the control core, the rate timer and the corrector.
// Assumes all three run on sys_clk.
`timescale 1ns/1ns
interface adcc_core_if;
	logic        xtal_tick;
	logic        run;
	logic [2:0]  rate_sel;
	logic        conv_end;
	logic [23:0] raw;
	logic [23:0] trim;
	logic [23:0] slope;
	logic [23:0] result;

	modport core  (output xtal_tick, run, rate_sel, raw, trim, slope, input conv_end, result);
	modport timer (input xtal_tick, run, rate_sel, output conv_end);
	modport corr  (input raw, trim, slope, output result);
endinterface

// >>> rtl/adcc_rate_timer.sv
// Conversion cycle timer counting crystal cycles for the selected rate.
// Assumes xtal_tick is a one-cycle pulse per crystal period.
`timescale 1ns/1ns
module adcc_rate_timer (
	// Clock and reset
	input wire logic      sys_clk,
	input wire logic      rst_n,
	input wire logic      ce,
	// Core link
	adcc_core_if.timer    core
);
	typedef struct packed {
		logic [14:0] cnt;
		logic        end_p;
	} adcc_tmr_t;

	adcc_tmr_t s_r;
	adcc_tmr_t s_nxt;

	// ------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.end_p = 1'b0;
		if (!core.run) begin
			s_nxt.cnt = 15'h0000;
		end else if (core.xtal_tick) begin
			if (s_r.cnt >= adcc_pkg::rate_cycles(core.rate_sel) - 15'h0001) begin // R26 R03
				s_nxt.cnt   = 15'h0000;
				s_nxt.end_p = 1'b1;
			end else begin
				s_nxt.cnt = s_r.cnt + 15'h0001;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			s_r <= '0;
		else if (ce)
			s_r <= s_nxt;
	end

	assign core.conv_end = s_r.end_p;
endmodule

// >>> rtl/adcc_corrector.sv
// Offset and gain correction of a raw conversion word.
// Assumes raw is bipolar two's complement; result is registered.
`timescale 1ns/1ns
module adcc_corrector (
	// Clock and reset
	input wire logic      sys_clk,
	input wire logic      rst_n,
	input wire logic      ce,
	// Core link
	adcc_core_if.corr     core
);
	typedef struct packed {
		logic [23:0] result;
	} adcc_corr_t;

	adcc_corr_t         s_r;
	adcc_corr_t         s_nxt;
	logic [25:0]        mag;
	logic [25:0]        diff;
	logic signed [50:0] prod;
	logic [28:0]        q;

	// ------------------------------------------------------------
	// Arithmetic
	// ------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		mag   = {3'b000, core.trim[22:0]};
		diff  = {{2{core.raw[23]}}, core.raw} - (core.trim[23] ? (26'h0 - mag) : mag); // R18 R19 R16
		prod  = $signed(diff) * $signed({1'b0, core.slope}); // R20
		q     = prod[50:22];
		if (q[28:23] == {6{q[23]}})
			s_nxt.result = q[23:0];
		else
			s_nxt.result = q[28] ? 24'h800000 : 24'h7FFFFF;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			s_r <= '0;
		else if (ce)
			s_r <= s_nxt;
	end

	assign core.result = s_r.result;
endmodule

// >>> verification/adcc_ctrl_asserts.sv
// Port-level checks on the converter control core.
// Assumes a bind onto adcc_ctrl with ce held high by the bench.
`timescale 1ns/1ns
module adcc_ctrl_asserts (
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        rst_n,
	// Watched ports
	input wire logic        cs_n,
	input wire logic        sdo,
	input wire logic        sdo_oe,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [2:0]  register_select_field,
	input wire logic [23:0] reg_wdata,
	input wire logic [23:0] reg_rdata,
	input wire logic        reg_rvalid,
	input wire logic        port_reset,
	input wire logic        conv_valid,
	input wire logic        reset_active,
	input wire logic [2:0]  cal_route
);
	logic cfg_wr;
	logic pf_r;

	// ----------------------------------------
	// Port flag mirror
	// ----------------------------------------
	assign cfg_wr = reg_wr && register_select_field == adcc_pkg::SEL_CONFIG;
	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			pf_r <= 1'b0;
		else if (cfg_wr)
			pf_r <= reg_wdata[adcc_pkg::CFG_PF];
		else if (port_reset)
			pf_r <= 1'b0;
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	a_read_answer: assert property (reg_rd |=> reg_rvalid)
		else $error("read strobe without answer");
	a_answer_cause: assert property (reg_rvalid |-> $past(reg_rd))
		else $error("read answer without strobe");
	a_rdata_holds: assert property (!reg_rvalid |-> $stable(reg_rdata))
		else $error("read data moved without answer");
	a_conv_single: assert property (conv_valid |=> !conv_valid)
		else $error("conversion pulse too long");
	a_reset_quiet: assert property (reset_active |-> !conv_valid && !cal_route[0])
		else $error("activity during reset cycle");
	a_reset_start: assert property (cfg_wr && reg_wdata[7] |-> ##[1:4] reset_active)
		else $error("reset bit did not start cycle");
	a_port_reset_end: assert property (port_reset |-> $past(reset_active) ##1 !port_reset)
		else $error("port reset outside cycle end");
	a_cal_start: assert property (cfg_wr && reg_wdata[1:0] != 2'h0 && !reg_wdata[7]
		&& !reset_active |-> ##[1:3] cal_route[0])
		else $error("calibration did not start");
	a_cal_sdo_low: assert property ($fell(cal_route[0]) && pf_r && !$past(reg_wr)
		|-> ##[0:2] !sdo)
		else $error("data out not low at calibration end");
	a_oe_select: assert property (!cs_n [*4] |-> sdo_oe)
		else $error("data out not driven while selected");
	a_oe_release: assert property (cs_n [*4] |-> !sdo_oe)
		else $error("data out driven while deselected");
endmodule

// >>> verification/adcc_host_model.sv
// Host side of the serial port: selects the part and clocks a word out.
// Assumes start is a one-cycle pulse set off the falling edge.
`timescale 1ns/1ns
module adcc_host_model (
	// Clock
	input  wire logic        sys_clk,
	// Serial pins
	output logic             cs_n,
	output logic             sclk,
	input  wire logic        sdo,
	input  wire logic        sdo_oe,
	// Bench control
	input  wire logic        start,
	input  wire logic [3:0]  half,
	output logic [23:0]      word,
	output logic             done
);
	logic pin;

	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		word = 24'h000000;
		done = 1'b0;
		pin = 1'b0;
	end

	// Released data line shows a changing pattern, never the last bit
	always @(negedge sys_clk)
		pin <= sdo_oe ? sdo : ~pin;

	// Select, then 24 clocks, MSB first; serial clock still outside frames
	always @(posedge sys_clk) begin
		if (start) begin
			cs_n <= 1'b0;
			repeat (8) @(negedge sys_clk);
			for (int i = 0; i < 24; i++) begin
				word <= {word[22:0], pin};
				sclk <= 1'b1;
				repeat (half) @(negedge sys_clk);
				sclk <= 1'b0;
				repeat (half) @(negedge sys_clk);
			end
			cs_n <= 1'b1;
			done <= 1'b1;
			@(negedge sys_clk);
			done <= 1'b0;
		end
	end
endmodule

// >>> verification/tb_adcc_ctrl.sv
// Self-checking bench for the converter control core.
// Assumes a fast crystal in place of the real one; counts are in ticks.
`timescale 1ns/1ns
module tb_adcc_ctrl;
	logic        sys_clk, rst_n, ce, xtal, cs_n, sclk, sdo, sdo_oe;
	logic        reg_wr, reg_rd, nop_cmd, reg_rvalid, port_reset;
	logic        conv_valid, reset_active, start, done;
	logic [2:0]  reg_sel, cal_route;
	logic [3:0]  half;
	logic [4:0]  probe;
	logic [8:0]  pins;
	logic [23:0] reg_wdata, reg_rdata, mod_word, word, off, gn, m, ex, e_v, m_v;
	logic [23:0] exp_q[$];
	logic [23:0] msk_q[$];
	logic [23:0] sh_q[$];
	int          failures = 0;
	int          comparisons = 0;
	int          seed;
	localparam logic [23:0] ALL = 24'hFFFFFF;

	assign probe = {done, port_reset, cal_route[1], cal_route[0], conv_valid};

	adcc_ctrl u_adcc_ctrl (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce),
		.crystal_clock_input(xtal), .crystal_drive_output(), .cs_n(cs_n),
		.sclk(sclk), .sdo(sdo), .sdo_oe(sdo_oe), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.register_select_field(reg_sel), .reg_wdata(reg_wdata), .nop_cmd(nop_cmd),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .port_reset(port_reset),
		.mod_word(mod_word), .conv_valid(conv_valid), .reset_active(reset_active),
		.cal_route(cal_route), .latch_a(pins[8:7]), .latch_d(pins[6:3]),
		.low_power(pins[2]), .unipolar(pins[1]), .power_save_sel(pins[0]));

	adcc_host_model u_adcc_host_model (.sys_clk(sys_clk), .cs_n(cs_n), .sclk(sclk),
		.sdo(sdo), .sdo_oe(sdo_oe), .start(start), .half(half), .word(word),
		.done(done));

	// ----------------------------------------
	// Clocks
	// ----------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	initial begin
		xtal = 1'b0;
		#37;
		forever #100 xtal = ~xtal;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic check(input string what, input logic [23:0] e, input logic [23:0] s);
		comparisons++;
		if (s !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, e, s);
		end
	endtask

	task automatic give_verdict();
		if (failures == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic wr(input logic [2:0] s, input logic [23:0] d);
		@(negedge sys_clk);
		reg_sel = s;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge sys_clk);
		reg_wr = 1'b0;
	endtask

	task automatic rd(input logic [2:0] s, input logic [23:0] e, input logic [23:0] k);
		@(negedge sys_clk);
		reg_sel = s;
		reg_rd = 1'b1;
		exp_q.push_back(e);
		msk_q.push_back(k);
		@(negedge sys_clk);
		reg_rd = 1'b0;
	endtask

	task automatic await(input int b, input logic v, input int n);
		int i;
		for (i = 0; i < n; i++) begin
			@(negedge sys_clk);
			if (probe[b] === v)
				break;
		end
		if (i == n)
			check("wait", 24'h000001, 24'h000000);
	endtask

	// Expected word: trim in sign and magnitude, gain with 22 fraction bits
	function automatic logic [23:0] corr(input logic [23:0] r, t, g);
		logic signed [25:0] d;
		logic signed [51:0] p;
		d = $signed({{2{r[23]}}, r});
		d = t[23] ? d + $signed({3'h0, t[22:0]}) : d - $signed({3'h0, t[22:0]});
		p = (d * $signed({1'b0, g})) >>> 22;
		if (p > 52'sh7FFFFF)
			return 24'h7FFFFF;
		if (p < -52'sh800000)
			return 24'h800000;
		return p[23:0];
	endfunction

	function automatic logic [23:0] sm(input logic [23:0] v);
		logic [23:0] a;
		a = v[23] ? 24'h000000 - v : v;
		return a[23] ? 24'hFFFFFF : {v[23], a[22:0]};
	endfunction

	// ----------------------------------------
	// Result monitor
	// ----------------------------------------
	always @(negedge sys_clk) begin
		if (reg_rvalid === 1'b1) begin
			e_v = exp_q.pop_front();
			m_v = msk_q.pop_front();
			check("read data", e_v & m_v, reg_rdata & m_v);
		end
		if (done === 1'b1)
			check("shifted word", sh_q.pop_front(), word);
	end

	initial begin
		#3000000;
		failures++;
		give_verdict();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		rst_n = 1'b0;
		ce = 1'b1;
		{reg_wr, reg_rd, nop_cmd, start} = 4'h0;
		reg_sel = 3'h0;
		reg_wdata = 24'h000000;
		mod_word = 24'h000000;
		half = 4'h5;
		seed = $urandom(96239);
		repeat (4) @(negedge sys_clk);
		rst_n = 1'b1;
		rd(adcc_pkg::SEL_CONFIG, adcc_pkg::CFG_RESET, ALL);
		rd(adcc_pkg::SEL_CONFIG, 24'h000000, ALL);
		rd(adcc_pkg::SEL_OFFSET, adcc_pkg::OFFSET_RESET, ALL);
		rd(adcc_pkg::SEL_GAIN, adcc_pkg::GAIN_RESET, ALL);
		rd(3'h7, 24'h000000, ALL);
		off = adcc_pkg::OFFSET_RESET;
		gn = adcc_pkg::GAIN_RESET;
		for (int k = 0; k < 2; k++) begin
			if (k == 1) begin
				off = 24'($urandom);
				gn = 24'($urandom);
				wr(adcc_pkg::SEL_OFFSET, off);
				wr(adcc_pkg::SEL_GAIN, gn);
				rd(adcc_pkg::SEL_OFFSET, off, ALL);
				rd(adcc_pkg::SEL_GAIN, gn, ALL);
			end
			m = 24'($urandom);
			mod_word = m;
			ex = corr(m, off, gn);
			wr(adcc_pkg::SEL_CONFIG, 24'h008020);
			await(0, 1'b1, 3000);
			rd(adcc_pkg::SEL_DATA, ex, ALL);
			@(negedge sys_clk);
			nop_cmd = 1'b1;
			@(negedge sys_clk);
			nop_cmd = 1'b0;
			half = (k == 1) ? 4'hC : 4'h5;
			sh_q.push_back(ex);
			start = 1'b1;
			@(negedge sys_clk);
			start = 1'b0;
			await(4, 1'b1, 1500);
		end
		for (int c = 1; c < 8; c++) begin
			if (c == 4)
				continue;
			m = 24'($urandom);
			mod_word = m;
			wr(adcc_pkg::SEL_CONFIG, 24'h008020 | 24'(c));
			await(1, 1'b1, 4);
			if (c[1:0] == 2'h3) begin
				await(2, 1'b1, 3000);
				rd(adcc_pkg::SEL_CONFIG, 24'h000000, 24'h000008);
			end
			await(1, 1'b0, 3000);
			rd(adcc_pkg::SEL_CONFIG, 24'h008028, ALL);
			if (c[0])
				off = sm(m);
			if (c[1])
				gn = m;
			if (c == 6) begin
				rd(adcc_pkg::SEL_SETUP, off, ALL);
				rd(adcc_pkg::SEL_CONFIG, 24'h000000, 24'h000008);
			end
			rd(adcc_pkg::SEL_OFFSET, off, ALL);
			rd(adcc_pkg::SEL_GAIN, gn, ALL);
			rd(adcc_pkg::SEL_CONFIG, 24'h008020, ALL);
		end
		wr(adcc_pkg::SEL_CONFIG, 24'h995010);
		check("latch pins", 24'h000137, {15'h0000, pins});
		wr(adcc_pkg::SEL_OFFSET, 24'h00A5A5);
		wr(adcc_pkg::SEL_CONFIG, 24'h000080);
		wr(adcc_pkg::SEL_OFFSET, 24'h0F0F0F);
		await(3, 1'b1, 6000);
		rd(adcc_pkg::SEL_CONFIG, 24'h0000C0, ALL);
		rd(adcc_pkg::SEL_OFFSET, adcc_pkg::OFFSET_RESET, ALL);
		rd(adcc_pkg::SEL_GAIN, adcc_pkg::GAIN_RESET, ALL);
		wr(adcc_pkg::SEL_CONFIG, 24'h000000);
		wr(adcc_pkg::SEL_OFFSET, 24'h000011);
		rd(adcc_pkg::SEL_OFFSET, 24'h000011, ALL);
		rd(adcc_pkg::SEL_CONFIG, 24'h000000, ALL);
		repeat (4) @(negedge sys_clk);
		give_verdict();
	end
endmodule

bind adcc_ctrl adcc_ctrl_asserts u_adcc_ctrl_asserts (.sys_clk(sys_clk), .rst_n(rst_n),
	.cs_n(cs_n), .sdo(sdo), .sdo_oe(sdo_oe), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.register_select_field(register_select_field), .reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .port_reset(port_reset),
	.conv_valid(conv_valid), .reset_active(reset_active), .cal_route(cal_route));
